// file: src/asc_top.sv
// converter control: register slave, sample sequencer and result buffer
module asc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system state and trigger sources
  input wire logic idle_mode,
  input wire logic timer3_compare,
  input wire logic external_interrupt_pin_zero,
  // converter core inputs
  input wire logic [11:0] analog_ch0,
  input wire logic [11:0] analog_ch1,
  input wire logic [11:0] analog_ch2,
  input wire logic [11:0] analog_ch3,
  // status
  output logic [3:0] sample_hold_active,
  output logic conversion_busy,
  output logic converter_interrupt_flag
);
  import asc_pkg::*;

  // bus state
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] awaddr_r, awaddr_nxt, araddr_cur;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  // registers and sequencer state
  logic [15:0] con1_r, con1_nxt, con2_r, con2_nxt, con3_r, con3_nxt;
  logic sample_r, sample_nxt, done_r, done_nxt;
  asc_state_type state_r, state_nxt;
  logic [4:0] samc_cnt_r, samc_cnt_nxt;
  logic [3:0] tad_cnt_r, tad_cnt_nxt, seq_cnt_r, seq_cnt_nxt;
  logic [3:0] wptr_r, wptr_nxt, sh_r, sh_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic irq_r, irq_nxt;
  logic [11:0] held_r [CHANNELS];
  logic [11:0] held_nxt [CHANNELS];
  logic [11:0] ana [CHANNELS];
  logic [15:0] buf_r [BUF_WORDS];
  // pin synchroniser
  logic external_interrupt_pin_zero_s1_r, external_interrupt_pin_zero_s2_r, external_interrupt_pin_zero_s3_r;
  // derived
  logic conv_on, res12, simultaneous_sample_select_eff, auto_sample_start, halt, run, tad_tick, trig_end;
  logic external_interrupt_pin_zero_edge, wr_fire, wr_con1, wr_con2, wr_con3, buf_we;
  logic [1:0] form, chps_eff, last_ch;
  logic [2:0] ssrc;
  logic [3:0] smpi, conv_len, used_mask;
  logic [4:0] samc;
  logic [11:0] raw_sel;
  logic [15:0] fmt_word, con1_wr;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CON1) || (a == OFS_CON2) || (a == OFS_CON3) ||
           (a == OFS_STAT) || (a[7:6] == BUF_PAGE && a[1:0] == 2'b00);
  endfunction

  assign ana[0] = analog_ch0;
  assign ana[1] = analog_ch1;
  assign ana[2] = analog_ch2;
  assign ana[3] = analog_ch3;

  assign conv_on = con1_r[B_ON];
  assign res12 = con1_r[B_RES];
  assign form = con1_r[B_FORM +: 2];
  assign ssrc = con1_r[B_SSRC +: 3];
  assign simultaneous_sample_select_eff = con1_r[B_SIMULTANEOUS_SAMPLE_SELECT] & ~res12;
  assign auto_sample_start = con1_r[B_AUTO_SAMPLE_START];
  assign chps_eff = res12 ? 2'b00 : con2_r[B_CHPS +: 2];
  assign smpi = con2_r[B_SMPI +: 4];
  assign samc = con3_r[B_SAMC +: 5];
  assign halt = con1_r[B_SIDL] & idle_mode;
  assign run = conv_on & ~halt;
  assign conv_len = res12 ? CONV_TAD_12 : CONV_TAD_10;
  assign last_ch = chps_eff[1] ? 2'd3 : {1'b0, chps_eff[0]};
  assign used_mask = chps_eff[1] ? 4'hf : (chps_eff[0] ? 4'h3 : 4'h1);
  assign external_interrupt_pin_zero_edge = external_interrupt_pin_zero_s2_r & ~external_interrupt_pin_zero_s3_r;
  // 10-bit mode keeps the top ten bits of the core value
  assign raw_sel = res12 ? held_r[ch_r] : {2'b00, held_r[ch_r][11:2]};

  asc_clk_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run && (state_r != ST_IDLE)),
    .divider(con3_r[B_ADCS +: 6]),
    .tad_tick(tad_tick)
  );

  asc_result_fmt u_fmt (
    .raw(raw_sel),
    .res12(res12),
    .form(form),
    .word(fmt_word)
  );

  always_comb begin
    case (ssrc)
      TRIG_SW: trig_end = ~sample_r;
      TRIG_EXTERNAL_INTERRUPT_PIN_ZERO: trig_end = external_interrupt_pin_zero_edge;
      TRIG_TMR3: trig_end = timer3_compare;
      TRIG_AUTO: trig_end = (samc_cnt_r >= samc);
      default: trig_end = 1'b0;
    endcase
  end

  // bus slave
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_con1 = wr_fire && (awaddr_r == OFS_CON1);
  assign wr_con2 = wr_fire && (awaddr_r == OFS_CON2);
  assign wr_con3 = wr_fire && (awaddr_r == OFS_CON3);
  assign araddr_cur = s_axi_araddr;

  always_comb begin
    logic [15:0] rd;
    rd = 16'h0000;
    aw_hold_nxt = aw_hold_r;
    awaddr_nxt = awaddr_r;
    w_hold_nxt = w_hold_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awaddr_r) ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      case (araddr_cur)
        OFS_CON1: rd = {con1_r[15:4], simultaneous_sample_select_eff, con1_r[B_AUTO_SAMPLE_START],
                        sample_r, done_r};
        OFS_CON2: rd = {6'h00, chps_eff, 2'b00, smpi, 2'b00};
        OFS_CON3: rd = con3_r;
        OFS_STAT: rd = {8'h00, wptr_r, 3'b000, state_r != ST_IDLE};
        default: rd = buf_r[araddr_cur[5:2]];
      endcase
      rvalid_nxt = 1'b1;
      rdata_nxt = mapped(araddr_cur) ? {16'h0000, rd} : 32'h00000000;
      rresp_nxt = mapped(araddr_cur) ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      awaddr_r <= awaddr_nxt;
      w_hold_r <= w_hold_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // registers and sequencer
  assign con1_wr = merge16(con1_r, wdata_r, wstrb_r);

  always_comb begin
    con1_nxt = con1_r;
    con2_nxt = con2_r;
    con3_nxt = con3_r;
    sample_nxt = sample_r;
    done_nxt = done_r;
    state_nxt = state_r;
    samc_cnt_nxt = samc_cnt_r;
    tad_cnt_nxt = tad_cnt_r;
    seq_cnt_nxt = seq_cnt_r;
    wptr_nxt = wptr_r;
    ch_nxt = ch_r;
    irq_nxt = 1'b0;
    buf_we = 1'b0;
    held_nxt = held_r;
    if (wr_con1) begin
      con1_nxt = (con1_r & ~CON1_WMASK) | (con1_wr & CON1_WMASK);
      if (conv_on) begin
        con1_nxt[B_RES] = con1_r[B_RES];
      end
      if (wstrb_r[0] && wdata_r[B_SAMPLE_ACTIVE] && !auto_sample_start) begin
        sample_nxt = 1'b1;
      end
      if (wstrb_r[0] && !wdata_r[B_SAMPLE_ACTIVE] && ssrc == TRIG_SW) begin
        sample_nxt = 1'b0;
      end
      if (wstrb_r[0] && !wdata_r[B_DONE]) begin
        done_nxt = 1'b0;
      end
    end
    if (wr_con2) begin
      con2_nxt = merge16(con2_r, wdata_r, wstrb_r) & CON2_WMASK;
    end
    if (wr_con3) begin
      con3_nxt = merge16(con3_r, wdata_r, wstrb_r) & CON3_WMASK;
    end
    // hardware updates come last so they beat a same-cycle software write, set or clear
    if (!conv_on) begin
      state_nxt = ST_IDLE;
      tad_cnt_nxt = 4'h0;
      samc_cnt_nxt = 5'h00;
      ch_nxt = 2'd0;
    end else if (run) begin
      case (state_r)
        ST_IDLE: begin
          if (sample_r || auto_sample_start) begin
            state_nxt = ST_SAMPLE;
            sample_nxt = 1'b1;
            samc_cnt_nxt = 5'h00;
          end
        end
        ST_SAMPLE: begin
          if (tad_tick && samc_cnt_r != 5'h1f) begin
            samc_cnt_nxt = samc_cnt_r + 5'h01;
          end
          if (trig_end) begin
            state_nxt = ST_CONVERT;
            sample_nxt = 1'b0;
            done_nxt = 1'b0;
            ch_nxt = 2'd0;
            tad_cnt_nxt = 4'h0;
            for (int i = 0; i < CHANNELS; i++) begin
              if (simultaneous_sample_select_eff || i == 0) begin
                held_nxt[i] = ana[i];
              end
            end
          end
        end
        ST_CONVERT: begin
          if (tad_tick && tad_cnt_r == conv_len - 4'h1) begin
            buf_we = 1'b1;
            wptr_nxt = wptr_r + 4'h1;
            tad_cnt_nxt = 4'h0;
            if (ch_r == last_ch) begin
              done_nxt = 1'b1;
              state_nxt = ST_IDLE;
              if (auto_sample_start) begin
                sample_nxt = 1'b1;
              end
              if (seq_cnt_r == smpi) begin
                irq_nxt = 1'b1;
                seq_cnt_nxt = 4'h0;
                wptr_nxt = 4'h0;
              end else begin
                seq_cnt_nxt = seq_cnt_r + 4'h1;
              end
            end else begin
              ch_nxt = 2'(ch_r + 2'd1);
              done_nxt = 1'b0;
              if (!simultaneous_sample_select_eff) begin
                held_nxt[2'(ch_r + 2'd1)] = ana[2'(ch_r + 2'd1)];
              end
            end
          end else if (tad_tick) begin
            tad_cnt_nxt = tad_cnt_r + 4'h1;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
    // sampling amplifiers track until their own hold moment
    sh_nxt = 4'h0;
    if (state_nxt == ST_SAMPLE) begin
      sh_nxt = used_mask;
    end else if (state_nxt == ST_CONVERT && !simultaneous_sample_select_eff) begin
      for (int i = 0; i < CHANNELS; i++) begin
        sh_nxt[i] = used_mask[i] && (i > int'(ch_nxt));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      con1_r <= CON_RST;
      con2_r <= CON_RST;
      con3_r <= CON_RST;
      sample_r <= 1'b0;
      done_r <= 1'b0;
      state_r <= ST_IDLE;
      samc_cnt_r <= 5'h00;
      tad_cnt_r <= 4'h0;
      seq_cnt_r <= 4'h0;
      wptr_r <= 4'h0;
      ch_r <= 2'd0;
      irq_r <= 1'b0;
      sh_r <= 4'h0;
      external_interrupt_pin_zero_s1_r <= 1'b0;
      external_interrupt_pin_zero_s2_r <= 1'b0;
      external_interrupt_pin_zero_s3_r <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        held_r[i] <= 12'h000;
      end
    end else begin
      con1_r <= con1_nxt;
      con2_r <= con2_nxt;
      con3_r <= con3_nxt;
      sample_r <= sample_nxt;
      done_r <= done_nxt;
      state_r <= state_nxt;
      samc_cnt_r <= samc_cnt_nxt;
      tad_cnt_r <= tad_cnt_nxt;
      seq_cnt_r <= seq_cnt_nxt;
      wptr_r <= wptr_nxt;
      ch_r <= ch_nxt;
      irq_r <= irq_nxt;
      sh_r <= sh_nxt;
      external_interrupt_pin_zero_s1_r <= external_interrupt_pin_zero;
      external_interrupt_pin_zero_s2_r <= external_interrupt_pin_zero_s1_r;
      external_interrupt_pin_zero_s3_r <= external_interrupt_pin_zero_s2_r;
      held_r <= held_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (buf_we) begin
      buf_r[wptr_r] <= fmt_word;
    end
  end

  assign sample_hold_active = sh_r;
  assign conversion_busy = (state_r == ST_CONVERT);
  assign converter_interrupt_flag = irq_r;
endmodule

// file: src/asc_pkg.sv
// constants, field layout and types of the converter sequencing block
// Operation
// - default 10-bit four sample-and-hold; resolution select gives 12-bit single channel
// - results go into a sixteen-word result buffer
// - converter on bit 15 of control one runs or stops the converter
// - idle-stop bit 13 halts the converter while the system is idle
// - 10-bit format 00 zero-filled, 01 fills with inverted bit 9
// - 12-bit format 00 zero-filled, 01 fills with inverted bit 11
// - trigger 111 counter, 010 timer three, 001 pin zero edge
// - simultaneous sampling of channels 0-3 or 0-1, else sequential
// - in 12-bit mode simultaneous-sample bit reads zero
// - auto-start resamples after each sequence and sets sample bit itself
// - software sets sample bit; clears it only with trigger 000
// - complete bit set at conversion end, cleared at new conversion start
// - software may only clear complete bit; clearing disturbs nothing
// - converter clock period is cycle period times divider plus one
// - channel count 00 one channel, 01 two, 1x four
// - interrupt after every Nth sequence, N is field plus one
// - counter trigger samples 0 to 31 converter clocks
package asc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CON1 = 8'h00;
  localparam logic [7:0] OFS_CON2 = 8'h04;
  localparam logic [7:0] OFS_CON3 = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [1:0] BUF_PAGE = 2'b01;
  localparam int BUF_WORDS = 16;
  localparam int CHANNELS = 4;
  // control one
  localparam int B_ON = 15;
  localparam int B_SIDL = 13;
  localparam int B_RES = 10;
  localparam int B_FORM = 8;
  localparam int B_SSRC = 5;
  localparam int B_SIMULTANEOUS_SAMPLE_SELECT = 3;
  localparam int B_AUTO_SAMPLE_START = 2;
  localparam int B_SAMPLE_ACTIVE = 1;
  localparam int B_DONE = 0;
  // control two and three
  localparam int B_CHPS = 8;
  localparam int B_SMPI = 2;
  localparam int B_SAMC = 8;
  localparam int B_ADCS = 0;
  // status
  localparam int B_BUSY = 0;
  localparam int B_WPTR = 4;
  localparam logic [15:0] CON1_WMASK = 16'ha7ec;
  localparam logic [15:0] CON2_WMASK = 16'h033c;
  localparam logic [15:0] CON3_WMASK = 16'h1f3f;
  localparam logic [15:0] CON_RST = 16'h0000;
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_EXTERNAL_INTERRUPT_PIN_ZERO = 3'h1;
  localparam logic [2:0] TRIG_TMR3 = 3'h2;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] FORM_SIGNED = 2'h1;
  localparam logic [3:0] CONV_TAD_10 = 4'hc;
  localparam logic [3:0] CONV_TAD_12 = 4'he;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} asc_state_type;
endpackage

// file: src/asc_clk_div.sv
// converter clock enable divided down from the instruction cycle
module asc_clk_div (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [5:0] divider,
  // enable
  output logic tad_tick
);
  import asc_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r + 6'h01;
    if (!run || cnt_r >= divider) begin
      cnt_nxt = 6'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // one pulse every divider plus one cycles
  assign tad_tick = run && (cnt_r >= divider);
endmodule

// file: src/asc_result_fmt.sv
// result formatting into a 16-bit buffer word
module asc_result_fmt (
  // result
  input wire logic [11:0] raw,
  input wire logic res12,
  input wire logic [1:0] form,
  // formatted word
  output logic [15:0] word
);
  import asc_pkg::*;

  always_comb begin
    if (res12) begin
      word = {4'h0, raw};
      if (form == FORM_SIGNED) begin
        word = {{4{~raw[11]}}, raw};
      end
    end else begin
      word = {6'h00, raw[9:0]};
      if (form == FORM_SIGNED) begin
        word = {{6{~raw[9]}}, raw[9:0]};
      end
    end
  end
endmodule

// file: dv/asc_analog_model.sv
// analog front end model: a tracked level per channel, inverted while held
module asc_analog_model (
  // sample state and level
  input wire logic [3:0] sample_hold_active,
  input wire logic [11:0] level,
  // converter core inputs
  output logic [11:0] analog_ch0,
  output logic [11:0] analog_ch1,
  output logic [11:0] analog_ch2,
  output logic [11:0] analog_ch3
);
  timeunit 1ns;
  timeprecision 1ps;
  // a held channel shows a wrong level, so a late capture is caught
  function automatic logic [11:0] lvl(input logic [11:0] b, input logic t,
                                      input int i);
    logic [11:0] v;
    v = b + 12'(i * 273);
    return t ? v : ~v;
  endfunction
  assign analog_ch0 = lvl(level, sample_hold_active[0], 0);
  assign analog_ch1 = lvl(level, sample_hold_active[1], 1);
  assign analog_ch2 = lvl(level, sample_hold_active[2], 2);
  assign analog_ch3 = lvl(level, sample_hold_active[3], 3);
endmodule

// file: dv/asc_top_asserts.sv
// concurrent checks on the converter control ports
module asc_top_asserts (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // bus
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  // status
  input logic [3:0] sample_hold_active,
  input logic conversion_busy,
  input logic converter_interrupt_flag
);
  import asc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid &&
      s_axi_awready && s_axi_arready && !conversion_busy &&
      sample_hold_active == 4'h0 && !converter_interrupt_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_wr_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("write not refused");
  property p_rd_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("read not refused");
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_DECERR;
  endproperty
  a_bresp: assert property (p_bresp) else $error("bad write response");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data set");
  property p_decerr;
    s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_decerr: assert property (p_decerr) else $error("unmapped read data");
  property p_conv_min;
    $rose(conversion_busy) |-> conversion_busy [*8];
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion short");
  property p_irq_pulse;
    converter_interrupt_flag |=> !converter_interrupt_flag;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_irq_end;
    converter_interrupt_flag |-> !conversion_busy &&
      ($past(conversion_busy) || $past(conversion_busy, 2));
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("irq off sequence");
  c_irq: cover property (converter_interrupt_flag);
  c_busy: cover property ($rose(conversion_busy));
  c_decerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule
bind asc_top asc_top_asserts u_asserts (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .sample_hold_active, .conversion_busy,
  .converter_interrupt_flag);

// file: dv/asc_tb_top.sv
// self-checking bench of the converter control block
module asc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic idle_mode = 0, tmr3 = 0, pin0 = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [11:0] level = 12'h5a7, a0, a1, a2, a3;
  logic awready, wready, bvalid, arready, rvalid, busy, irq;
  logic [1:0] bresp, rresp;
  logic [3:0] sha;
  int miscompares = 0, checks = 0, cyc = 0, irq_at = 0, irq_gap = 0;
  int irq_cnt = 0, busy_cnt = 0;
  asc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .idle_mode(idle_mode), .timer3_compare(tmr3),
    .external_interrupt_pin_zero(pin0), .analog_ch0(a0), .analog_ch1(a1),
    .analog_ch2(a2), .analog_ch3(a3), .sample_hold_active(sha),
    .conversion_busy(busy), .converter_interrupt_flag(irq));
  asc_analog_model u_model (.sample_hold_active(sha), .level(level),
    .analog_ch0(a0), .analog_ch1(a1), .analog_ch2(a2), .analog_ch3(a3));
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (busy) busy_cnt++;
    if (irq) begin
      irq_gap = cyc - irq_at;
      irq_at = cyc;
      irq_cnt++;
    end
  end
  task automatic check(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    output logic [1:0] r);
    logic aw, wd;
    aw = 0;
    wd = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && wd)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", r, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata[15:0];
    r = rresp;
  endtask
  task automatic rv(input string n, input logic [7:0] a,
                    input logic [15:0] m, e);
    logic [15:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(n, d & m, e);
  endtask
  task automatic wait_done();
    logic [15:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(OFS_CON1, d, r);
      n++;
    end while (!d[B_DONE] && n < 200);
    check("done", d[B_DONE], 1'b1);
  endtask
  function automatic logic [15:0] fmt(input int i, input logic r12, s);
    logic [11:0] v;
    v = level + 12'(i * 273);
    if (r12) return s ? {{4{~v[11]}}, v} : {4'h0, v};
    return s ? {{6{~v[11]}}, v[11:2]} : {6'h00, v[11:2]};
  endfunction
  task automatic t_regs();
    logic [15:0] d;
    logic [1:0] r;
    rv("con1_rst", OFS_CON1, 16'hffff, CON_RST);
    rv("con2_rst", OFS_CON2, 16'hffff, CON_RST);
    rv("con3_rst", OFS_CON3, 16'hffff, CON_RST);
    w(OFS_CON2, 16'hffff);
    rv("con2_mask", OFS_CON2, 16'hffff, CON2_WMASK);
    w(OFS_CON3, 16'hffff);
    rv("con3_mask", OFS_CON3, 16'hffff, CON3_WMASK);
    w(OFS_CON1, 16'h27ec);
    rv("simultaneous_sample_select_12", OFS_CON1, 16'hfffc, 16'h27e4);
    w(OFS_CON1, 16'h0000);
    w(OFS_CON2, 16'h0000);
    w(OFS_CON3, 16'h0002);
    wr(8'h30, 16'h1234, r);
    check("unmapped_wr", r, RESP_DECERR);
    rd(8'h30, d, r);
    check("unmapped_rd", {r, d[13:0]}, {RESP_DECERR, 14'h0});
  endtask
  task automatic t_sw(input logic [1:0] f, input logic stop);
    logic [15:0] c;
    c = 16'h8000 | (16'(stop) << B_SIDL) | (16'(f) << B_FORM);
    w(OFS_CON1, c | 16'h0002);
    repeat (3) @(posedge aclk);
    rv("sampling", OFS_CON1, 16'h0003, 16'h0002);
    busy_cnt = 0;
    w(OFS_CON1, c);
    w(OFS_CON1, c);
    idle_mode <= 1;
    repeat (50) @(posedge aclk);
    check("idle_hold", busy, stop);
    idle_mode <= 0;
    wait_done();
    if (!stop) check("conv_cycles", busy_cnt inside {[33:39]}, 1'b1);
    rv("result", 8'h40, 16'hffff, fmt(0, 0, f[0]));
  endtask
  task automatic t_trig(input logic [2:0] t);
    logic [15:0] c;
    c = 16'h8000 | (16'(t) << B_SSRC);
    w(OFS_CON1, c | 16'h0002);
    repeat (20) @(posedge aclk);
    check("wait_trig", busy, 1'b0);
    if (t != TRIG_EXTERNAL_INTERRUPT_PIN_ZERO) tmr3 <= 1;
    if (t != TRIG_TMR3) pin0 <= 1;
    repeat (4) @(posedge aclk);
    tmr3 <= 0;
    pin0 <= 0;
    if (t == 3'h3) begin
      repeat (50) @(posedge aclk);
      rv("reserved_trig", OFS_CON1, 16'h0002, 16'h0002);
      w(OFS_CON1, c | 16'h0002);
      w(OFS_CON1, 16'h0062);
      rv("off_kept", OFS_CON1, 16'hffe2, 16'h0062);
    end else begin
      wait_done();
      rv("trig_result", 8'h40, 16'hffff, fmt(0, 0, 0));
    end
  endtask
  task automatic t_res12();
    w(OFS_CON1, 16'h8000);
    w(OFS_CON1, 16'h8400);
    rv("res_locked", OFS_CON1, 16'h0400, 16'h0000);
    repeat (4) @(posedge aclk);
    w(OFS_CON1, 16'h0400);
    level <= 12'hc3e;
    w(OFS_CON1, 16'h8508);
    rv("simultaneous_sample_select_off", OFS_CON1, 16'hfffc, 16'h8500);
    w(OFS_CON1, 16'h8502);
    w(OFS_CON1, 16'h8500);
    wait_done();
    rv("res12", 8'h40, 16'hffff, fmt(0, 1, 1));
    w(OFS_CON1, 16'h0000);
  endtask
  task automatic t_auto(input logic sim);
    int k;
    w(OFS_CON2, 16'h0204);
    w(OFS_CON3, 16'h0100);
    w(OFS_CON1, 16'h80e4 | (16'(sim) << B_SIMULTANEOUS_SAMPLE_SELECT));
    k = irq_cnt;
    for (int n = 0; n < 3000 && irq_cnt < k + 2; n++) @(posedge aclk);
    check("irq_gap", irq_gap inside {[96:120]}, 1'b1);
    while (!busy) @(posedge aclk);
    rv("done_cleared", OFS_CON1, 16'h0001, 16'h0000);
    repeat (4) @(posedge aclk);
    w(OFS_CON1, 16'h00e4 | (16'(sim) << B_SIMULTANEOUS_SAMPLE_SELECT));
    repeat (2) @(posedge aclk);
    check("off_idle", {busy, sha}, 5'h00);
    for (int i = 0; i < 8; i++)
      rv("buffer", 8'(8'h40 + 4 * i), 16'hffff, fmt(i % 4, 0, 0));
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_sw(2'b00, 1'b0);
    t_sw(2'b01, 1'b1);
    for (int t = 1; t < 4; t++) t_trig(3'(t));
    t_res12();
    t_auto(1'b1);
    t_auto(1'b0);
    conclude();
  end
  initial begin
    #300us;
    miscompares++;
    conclude();
  end
endmodule
